// ==== hdl/auxadc_mode_rom.sv ====
`timescale 1ns/1ns
`default_nettype none
// mode table: start period and settling time in clock cycles, registered out
module auxadc_mode_rom
    import auxadc_pkg::*;
(
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    input  wire logic [2:0]              mode,
    output logic      [AUXADC_CNT_W-1:0] period_cyc,
    output logic      [AUXADC_CNT_W-1:0] settle_cyc
);

    // sample rates in Hz and latencies in us per mode
    localparam int RATE_HZ [5] = '{5859, 11700, 46875, 93750, 187000};
    localparam int SETL_US [5] = '{171, 85, 21, 11, 5};

    logic [AUXADC_CNT_W-1:0] per_tab [5];
    logic [AUXADC_CNT_W-1:0] set_tab [5];

    // period rounds up (least time), settling is a whole-microsecond product so it needs no rounding
    genvar g;
    generate
        for (g = 0; g < 5; g++) begin : g_tab
            assign per_tab[g] = AUXADC_CNT_W'((AUXADC_CLK_MHZ * 1000000 + RATE_HZ[g] - 1) / RATE_HZ[g]);
            assign set_tab[g] = AUXADC_CNT_W'(SETL_US[g] * AUXADC_CLK_MHZ);
        end
    endgenerate

    // registered lookup, illegal modes fall to the slowest entry
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            period_cyc <= '0;
            settle_cyc <= '0;
        end else if (mode < AUXADC_NUM_MODE) begin
            period_cyc <= per_tab[mode];
            settle_cyc <= set_tab[mode];
        end else begin
            period_cyc <= per_tab[0];
            settle_cyc <= set_tab[0];
        end
    end

endmodule
`default_nettype wire

// ==== hdl/auxadc_pkg.sv ====
package auxadc_pkg;

    // register byte offsets
    localparam logic [7:0] AUXADC_OFS_CTRL   = 8'h00;
    localparam logic [7:0] AUXADC_OFS_STATUS = 8'h04;
    localparam logic [7:0] AUXADC_OFS_SAMPLE = 8'h08;
    localparam logic [7:0] AUXADC_OFS_COUNT  = 8'h0C;

    // control register field positions
    localparam int AUXADC_CTRL_EN_BIT   = 0;
    localparam int AUXADC_CTRL_REF_BIT  = 1;
    localparam int AUXADC_CTRL_RNG_LSB  = 4;
    localparam int AUXADC_CTRL_MODE_LSB = 8;
    localparam int AUXADC_CTRL_CH_LSB   = 12;
    localparam int AUXADC_CTRL_ALT_BIT  = 16;

    // status register field positions
    localparam int AUXADC_STAT_ST_LSB   = 0;
    localparam int AUXADC_STAT_SETL_BIT = 2;
    localparam int AUXADC_STAT_VLD_BIT  = 3;
    localparam int AUXADC_STAT_TMO_BIT  = 4;
    localparam int AUXADC_STAT_PEND_BIT = 5;

    // channel and mode counts, range encodings
    localparam int         AUXADC_NUM_CH   = 9;
    localparam logic [1:0] AUXADC_RNG_3V6  = 2'h0;
    localparam logic [1:0] AUXADC_RNG_2V4  = 2'h1;
    localparam logic [1:0] AUXADC_RNG_1V2  = 2'h2;
    localparam logic [2:0] AUXADC_NUM_MODE = 3'h5;

    // timing
    localparam int AUXADC_CLK_MHZ     = 125;
    localparam int AUXADC_CONV_NS     = 10000;
    localparam int AUXADC_CONV_CYC    = AUXADC_CONV_NS * AUXADC_CLK_MHZ / 1000;
    localparam int AUXADC_CEIL_HZ     = 187000;
    // least period between starts: round up
    localparam int AUXADC_CEIL_CYC    = (AUXADC_CLK_MHZ * 1000000 + AUXADC_CEIL_HZ - 1) / AUXADC_CEIL_HZ;
    localparam int AUXADC_CNT_W       = 16;

    typedef enum logic [1:0] {
        AUXADC_IDLE = 2'b00,
        AUXADC_CONV = 2'b01,
        AUXADC_GAP  = 2'b10
    } auxadc_state_e;

    // firmware configuration carried together
    typedef struct packed {
        logic       en;
        logic       ref_bg;
        logic [1:0] rng;
        logic [2:0] mode;
        logic [3:0] ch;
        logic       alt;
    } auxadc_cfg_s;

    typedef struct packed {
        logic [15:0] data;
        logic        valid;
    } auxadc_sample_s;

endpackage

// ==== hdl/auxadc_seq.sv ====
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// R1: nine channels, one pin of each pair
// R2: conversion result ready within ten microseconds
// R3: supply or bandgap reference, firmware selected
// R4: starts never faster than 187 kHz
// R5: process raw core output into samples
// R6: drive input and reference mux selects
// R7: three input ranges: 3.6, 2.4, 1.2 V
// R8: five modes with their sampling rates
// R9: drop samples during per-mode settling latency
// R10: samples presented as 16-bit words
// R11: valid strobe, sample held until replaced
// R12: apply settings at conversion boundary, resettle
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ns
`default_nettype none
module auxadc_seq
    import auxadc_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             conv_start,
    input  wire logic        conv_done,
    input  wire logic [15:0] conv_raw,
    output logic      [3:0]  inp_mux_sel,
    output logic             pin_alt_sel,
    output logic             ref_bg_sel,
    output logic      [1:0]  range_sel,
    output logic      [15:0] sample_data,
    output logic             sample_valid
);

    //////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        auxadc_cfg_s             shadow;
        auxadc_cfg_s             active;
        auxadc_state_e           st;
        logic [AUXADC_CNT_W-1:0] conv_cnt;
        logic [AUXADC_CNT_W-1:0] gap_cnt;
        logic [AUXADC_CNT_W-1:0] settle_cnt;
        logic                    wr_pend;
        logic [7:0]              addr;
        logic                    start;
        auxadc_sample_s          smp;
        logic                    timeout;
        logic [15:0]             smp_count;
        logic                    reload;
    } auxadc_st_s;

    auxadc_st_s              st_ff;
    auxadc_st_s              nxt_st;
    logic [AUXADC_CNT_W-1:0] period_cyc;
    logic [AUXADC_CNT_W-1:0] settle_cyc;
    logic [31:0]             rd_mux;
    logic                    cfg_changed;
    logic                    bus_go;
    logic                    conv_end;
    logic                    gap_over;

    // table lookup for the mode being applied; the table is registered, so its
    // outputs follow the applied mode one cycle later, which is why the settling
    // count is loaded in the cycle after a change is applied
    auxadc_mode_rom u_rom (
        .hclk       (hclk),
        .hresetn    (hresetn),
        .mode       (nxt_st.active.mode),
        .period_cyc (period_cyc),
        .settle_cyc (settle_cyc)
    );

    //////////////////////////////////////////////////////////////////////////
    // read mux
    // read data come from registered state and stand through the data phase
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (st_ff.addr)
            AUXADC_OFS_CTRL: begin
                rd_mux[AUXADC_CTRL_EN_BIT]                       = st_ff.shadow.en;
                rd_mux[AUXADC_CTRL_REF_BIT]                      = st_ff.shadow.ref_bg;
                rd_mux[AUXADC_CTRL_RNG_LSB +: 2]                 = st_ff.shadow.rng;
                rd_mux[AUXADC_CTRL_MODE_LSB +: 3]                = st_ff.shadow.mode;
                rd_mux[AUXADC_CTRL_CH_LSB +: 4]                  = st_ff.shadow.ch;
                rd_mux[AUXADC_CTRL_ALT_BIT]                      = st_ff.shadow.alt;
            end
            AUXADC_OFS_STATUS: begin
                // state, settling, valid pulse, last conversion timed out, change pending
                rd_mux[AUXADC_STAT_ST_LSB +: 2] = st_ff.st;
                rd_mux[AUXADC_STAT_SETL_BIT]    = (st_ff.settle_cnt != '0);
                rd_mux[AUXADC_STAT_VLD_BIT]     = st_ff.smp.valid;
                rd_mux[AUXADC_STAT_TMO_BIT]     = st_ff.timeout;
                rd_mux[AUXADC_STAT_PEND_BIT]    = cfg_changed;
            end
            AUXADC_OFS_SAMPLE: rd_mux[15:0] = st_ff.smp.data;
            AUXADC_OFS_COUNT:  rd_mux[15:0] = st_ff.smp_count;
            default:           rd_mux = 32'h0000_0000; // unmapped reads zero
        endcase
    end

    assign cfg_changed = (st_ff.shadow != st_ff.active);
    assign bus_go      = hsel & hready & htrans[1];

    // conversion boundary: the core answered or its time ran out
    assign conv_end    = conv_done || (st_ff.conv_cnt == AUXADC_CNT_W'(AUXADC_CONV_CYC - 1)); // [R2]
    // next start allowed once both the mode period and the absolute ceiling are met;
    // the two cycles taken off cover the idle cycle and the start register
    assign gap_over    = (st_ff.gap_cnt >= period_cyc - 2'd2) &&
                         (st_ff.gap_cnt >= AUXADC_CNT_W'(AUXADC_CEIL_CYC - 2));      // [R4] [R8]

    //////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        nxt_st           = st_ff;
        nxt_st.start     = 1'b0;
        nxt_st.smp.valid = 1'b0;
        nxt_st.reload    = 1'b0;
        // bus address phase capture, zero-wait slave
        if (bus_go) begin
            nxt_st.wr_pend = hwrite;
            nxt_st.addr    = haddr[7:0];
        end else if (hready) begin
            nxt_st.wr_pend = 1'b0;
        end
        // data phase write into shadow
        // illegal range, mode or channel codes keep the old setting
        if (st_ff.wr_pend && st_ff.addr == AUXADC_OFS_CTRL) begin
            nxt_st.shadow.en     = hwdata[AUXADC_CTRL_EN_BIT];
            nxt_st.shadow.ref_bg = hwdata[AUXADC_CTRL_REF_BIT];              // [R3]
            nxt_st.shadow.rng    = (hwdata[AUXADC_CTRL_RNG_LSB +: 2] > AUXADC_RNG_1V2)
                                   ? st_ff.shadow.rng : hwdata[AUXADC_CTRL_RNG_LSB +: 2]; // [R7]
            nxt_st.shadow.mode   = (hwdata[AUXADC_CTRL_MODE_LSB +: 3] >= AUXADC_NUM_MODE)
                                   ? st_ff.shadow.mode : hwdata[AUXADC_CTRL_MODE_LSB +: 3]; // [R8]
            nxt_st.shadow.ch     = (hwdata[AUXADC_CTRL_CH_LSB +: 4] >= 4'(AUXADC_NUM_CH))
                                   ? st_ff.shadow.ch : hwdata[AUXADC_CTRL_CH_LSB +: 4]; // [R1]
            nxt_st.shadow.alt    = hwdata[AUXADC_CTRL_ALT_BIT];             // [R1]
        end
        // sequencer
        unique case (st_ff.st)
            AUXADC_IDLE: begin
                // a pending change wins over a new start, so it lands between conversions
                if (cfg_changed) begin
                    nxt_st.active     = st_ff.shadow;                     // [R12]
                    nxt_st.reload     = 1'b1;                             // [R9]
                end else if (st_ff.active.en) begin
                    nxt_st.start    = 1'b1;
                    nxt_st.st       = AUXADC_CONV;
                    nxt_st.conv_cnt = '0;
                    nxt_st.gap_cnt  = '0;
                end
            end
            AUXADC_CONV: begin
                // count both the conversion time and the start-to-start spacing
                nxt_st.conv_cnt = st_ff.conv_cnt + 1'b1;
                nxt_st.gap_cnt  = st_ff.gap_cnt + 1'b1;
                if (conv_end) begin                                       // [R2]
                    // a silent core leaves the last sample in place and flags the timeout
                    nxt_st.timeout = !conv_done;
                    // samples taken while the input settles are dropped
                    if (conv_done && st_ff.settle_cnt == '0) begin        // [R9]
                        nxt_st.smp.data  = conv_raw;                      // [R5] [R10] [R11]
                        nxt_st.smp.valid = 1'b1;                          // [R11]
                        nxt_st.smp_count = st_ff.smp_count + 1'b1;
                    end
                    nxt_st.st = AUXADC_GAP;
                end
            end
            AUXADC_GAP: begin
                nxt_st.gap_cnt = st_ff.gap_cnt + 1'b1;
                // hold off next start to mode period and ceiling
                if (gap_over) begin                                       // [R4] [R8]
                    nxt_st.st = AUXADC_IDLE;
                end
            end
            default: nxt_st.st = AUXADC_IDLE;
        endcase
        // settling countdown runs in real time
        if (st_ff.settle_cnt != '0) begin
            nxt_st.settle_cnt = st_ff.settle_cnt - 1'b1;                  // [R9]
        end
        // restart settling once the table shows the newly applied mode
        if (st_ff.reload) begin
            nxt_st.settle_cnt = settle_cyc;                               // [R9] [R12]
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // outputs
    // zero wait, always okay: every transfer ends in its first data phase
    assign hreadyout    = 1'b1;
    assign hresp        = 1'b0;
    assign hrdata       = rd_mux;               // read data from registered state
    assign conv_start   = st_ff.start;
    assign inp_mux_sel  = st_ff.active.ch;      // [R6]
    assign pin_alt_sel  = st_ff.active.alt;     // [R1] [R6]
    assign ref_bg_sel   = st_ff.active.ref_bg;  // [R6]
    assign range_sel    = st_ff.active.rng;     // [R7]
    assign sample_data  = st_ff.smp.data;       // [R11]
    assign sample_valid = st_ff.smp.valid;

endmodule
`default_nettype wire

// ==== verif/aux_adc_sequencer_bench.sv ====
`timescale 1ns/1ns
`default_nettype none
module aux_adc_sequencer_bench;
    import auxadc_pkg::*;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, slow = 0, en;
    logic        hreadyout, hresp, conv_start, conv_done, pin_alt_sel, ref_bg_sel, sample_valid;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, rd, wv;
    logic [1:0]  htrans = 0, range_sel;
    logic [2:0]  hsize = 3'h2;
    logic [15:0] conv_raw, sample_data, exp_raw;
    logic [3:0]  inp_mux_sel;
    int          miscompares = 0, check_count = 0, cyc = 0, seed = 524;
    always #4 hclk = ~hclk;
    auxadc_seq auxadc_seq_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .conv_start(conv_start),
        .conv_done(conv_done), .conv_raw(conv_raw), .inp_mux_sel(inp_mux_sel),
        .pin_alt_sel(pin_alt_sel), .ref_bg_sel(ref_bg_sel), .range_sel(range_sel),
        .sample_data(sample_data), .sample_valid(sample_valid));
    auxadc_core_model auxadc_core_model_i (.hclk(hclk), .hresetn(hresetn), .conv_start(conv_start),
        .slow(slow), .conv_done(conv_done), .conv_raw(conv_raw));
    // capture core word, cut a hang short
    always @(posedge hclk) begin
        if (conv_done) exp_raw <= conv_raw;
        cyc++;
        if (cyc == 60000) begin
            miscompares++;
            report_and_stop();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected at %0t got %h exp %h", $time, g, e);
        end
    endtask
    // one single ahb transfer, address phase then data phase
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        // data phase ends at the edge that sees hready; read data taken there
        do @(posedge hclk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask
    task automatic report_and_stop();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    // per channel: range, mode, reference, pin of pair; then a sample on channels 1 to 8 (channel 0 runs disabled)
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        xfer(AUXADC_OFS_CTRL, 1'b0, 32'h0, rd);
        chk(rd, 32'h0);
        for (int i = 0; i < 9; i++) begin
            en = (i != 0);
            slow <= i[0];
            wv = {15'h0, 1'($random(seed)), 4'(i), 1'b0, 3'((i < 5) ? i : 4), 2'b0, 2'(i % 3), 2'b0,
                  1'($random(seed)), en};
            xfer(AUXADC_OFS_CTRL, 1'b1, wv, rd);
            xfer(AUXADC_OFS_CTRL, 1'b0, 32'h0, rd);
            chk(rd, wv);
            // a sample of the old setting may still come in; wait for one on the new channel
            for (int n = 0; n < 30000 && !(inp_mux_sel === 4'(i) && (!en || sample_valid === 1'b1)); n++)
                @(posedge hclk) #1;
            chk(32'(inp_mux_sel === 4'(i) && (!en || sample_valid === 1'b1)), 32'h1);
            chk({inp_mux_sel, pin_alt_sel, ref_bg_sel, range_sel},
                {wv[15:12], wv[16], wv[1], wv[5:4]});
            if (en) begin
                chk(sample_data, exp_raw);
                xfer(AUXADC_OFS_SAMPLE, 1'b0, 32'h0, rd);
                chk(rd, {16'h0, exp_raw});
            end
        end
        // illegal channel, mode and range codes: every field keeps its value
        xfer(AUXADC_OFS_CTRL, 1'b1, wv | 32'h0000F730, rd);
        xfer(AUXADC_OFS_CTRL, 1'b0, 32'h0, rd);
        chk(rd, wv);
        xfer(8'h10, 1'b1, 32'hFFFFFFFF, rd);
        xfer(8'h10, 1'b0, 32'h0, rd);
        chk(rd, 32'h0);
        report_and_stop();
    end
endmodule
bind auxadc_seq auxadc_seq_asserts auxadc_seq_asserts_i (.hclk(hclk), .hresetn(hresetn),
    .conv_start(conv_start), .conv_done(conv_done), .conv_raw(conv_raw), .inp_mux_sel(inp_mux_sel),
    .pin_alt_sel(pin_alt_sel), .ref_bg_sel(ref_bg_sel), .range_sel(range_sel),
    .sample_data(sample_data), .sample_valid(sample_valid));
`default_nettype wire

// ==== verif/auxadc_core_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module auxadc_core_model (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        conv_start,
    input  wire logic        slow,
    output logic             conv_done,
    output logic      [15:0] conv_raw
);
    int   mseed = 524;
    int   wait_n;
    logic run;
    // one conversion at a time; result word only valid with done
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            conv_done <= 1'b0;
            conv_raw  <= 16'hA5A5;
            run       <= 1'b0;
        end else begin
            conv_done <= 1'b0;
            conv_raw  <= ~conv_raw; // junk between results
            if (conv_start) begin
                run    <= 1'b1;
                wait_n <= slow ? 1240 : 3 + ($random(mseed) & 31);
            end else if (run && wait_n == 0) begin
                run       <= 1'b0;
                conv_done <= 1'b1;
                conv_raw  <= 16'($random(mseed));
            end else if (run) begin
                wait_n <= wait_n - 1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== verif/auxadc_seq_asserts.sv ====
`timescale 1ns/1ns
`default_nettype none
module auxadc_seq_asserts (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        conv_start,
    input wire logic        conv_done,
    input wire logic [15:0] conv_raw,
    input wire logic [3:0]  inp_mux_sel,
    input wire logic        pin_alt_sel,
    input wire logic        ref_bg_sel,
    input wire logic [1:0]  range_sel,
    input wire logic [15:0] sample_data,
    input wire logic        sample_valid
);
    logic [15:0] gap_ff;
    logic [15:0] stl_ff;
    logic        busy_ff;
    wire  [7:0]  sel = {inp_mux_sel, pin_alt_sel, ref_bg_sel, range_sel};
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // cycles since last start, since last select change, core busy
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gap_ff  <= 16'hFFFF;
            stl_ff  <= 16'hFFFF;
            busy_ff <= 1'b0;
        end else begin
            gap_ff  <= conv_start ? 16'h0000 : gap_ff + {15'h0000, gap_ff != 16'hFFFF};
            stl_ff  <= $changed(sel) ? 16'h0000 : stl_ff + {15'h0000, stl_ff != 16'hFFFF};
            busy_ff <= conv_start | (busy_ff & ~conv_done);
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    sequence s_result;
        conv_done ##1 sample_valid;
    endsequence
    property p_rate; conv_start |-> gap_ff >= 16'd668; endproperty
    property p_raw; s_result |-> sample_data == $past(conv_raw); endproperty
    property p_cause; sample_valid |-> $past(conv_done) && stl_ff >= 16'd624; endproperty
    property p_pulse; sample_valid |=> !sample_valid; endproperty
    property p_hold; $changed(sample_data) |-> sample_valid; endproperty
    property p_frozen; busy_ff |-> $stable(sel); endproperty
    property p_legal; inp_mux_sel <= 4'h8 && range_sel != 2'h3; endproperty
    property p_one; conv_start |-> !busy_ff; endproperty
    a_rate: assert property (p_rate) else $error("starts too close");
    a_raw: assert property (p_raw) else $error("sample differs from core word");
    a_cause: assert property (p_cause) else $error("sample without result or settling");
    a_pulse: assert property (p_pulse) else $error("valid longer than one cycle");
    a_hold: assert property (p_hold) else $error("sample changed without valid");
    a_frozen: assert property (p_frozen) else $error("selects moved in conversion");
    a_legal: assert property (p_legal) else $error("illegal channel or range");
    a_one: assert property (p_one) else $error("start while core busy");
endmodule
`default_nettype wire
